// file: hw/bosr_regs.sv
`timescale 1ns/1ps
`include "bosr_defs.svh"

// What this block does
// - Presence register is read-only and answers only in board setup mode.
// - Variant 1: bits 3,2 give connector 2; 00 is 1MB, 11 empty.
// - Variant 1: bits 1,0 give connector 1 with the same coding.
// - Variant 2: bit 3 size strap, bit 2 presence strap of connector 2.
// - Variant 2: bits 1,0 give connector 1; 10 is 2MB, 11 invalid.
// - Variant 3: bits 6,3 type code of connector 2; 01 is 4MB.
// - Variant 3: bits 5,1 type code of connector 1; 01 is 4MB.
// - Variant 3: bit 4 reads 0 when the service pin is grounded.
// - Variant 3: bit 2 is connector 1 presence, 0 when fitted.
// - Variant 3: bit 0 is connector 2 presence, 0 when fitted.
// - Variant 3 second register: bits 5,4 speed, 0 for 80 ns cards.
// - Variant 3 second register: bits 3,2 pass the cache card id lines.
// - Second register bit 0 set disables the 4KB RAM window at E0000.
// - Control bit 7 drives channel reset to all connectors while set.
// - Control bit 3 enables the connector select chosen by bits 2-0.
// - Select field values 0-7 address connectors 1-8, one line each.
// - Selected adapter answers option cycles at 0100-0107.
// - Connector select follows I/O cycles at 0100-0107 one clock later, and only those.
// - Control reads return stored bits with bits 6,5,4 as 1.
module bosr_regs #(
   parameter int                    ADDR_W        = 16,
   parameter int                    SEL_W         = 3,
   parameter bosr_pkg::bosr_variant_t BOARD_VARIANT = bosr_pkg::BOSR_VAR_3
) (
   // Clock, reset, enable
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                ce,
   // I/O cycle port
   input  wire logic                io_active,
   input  wire logic                io_strobe,
   input  wire logic                io_write,
   input  wire logic [ADDR_W-1:0]   io_addr,
   input  wire logic [7:0]          io_wdata,
   output logic      [7:0]          io_rdata,
   output logic                     io_rvalid,
   // Board setup mode from the board enable logic
   input  wire logic                sys_setup,
   // Memory connector straps
   input  wire logic [1:0]          type_strap_a,
   input  wire logic [1:0]          type_strap_b,
   input  wire logic [1:0]          mem_present_n,
   input  wire logic                service_override_n,
   input  wire logic                slot1_fast_mem_n,
   input  wire logic                slot2_fast_mem_n,
   input  wire logic [1:0]          cache_card_id,
   input  wire logic                ram_window_strap,
   // Board side control
   output logic                     ram_window_off,
   // Expansion connector lines
   output logic                     chan_reset,
   output logic [(1<<SEL_W)-1:0]    slot_config_select_n
);

   localparam int NSLOT = 1 << SEL_W;

   // Address compare used by every register decode
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [15:0] off);
      addr_is = (a == ADDR_W'(off));
   endfunction

   // Option register window of the selected adapter
   function automatic logic addr_in_opt(input logic [ADDR_W-1:0] a);
      addr_in_opt = (a >= ADDR_W'(`BOSR_ADDR_OPT_LO)) &&
                    (a <= ADDR_W'(`BOSR_ADDR_OPT_HI));
   endfunction

   // Stored control bits
   logic       ctl_reset;
   logic       ctl_enable;
   logic [SEL_W-1:0] ctl_sel;

   // Address decode
   wire logic hit_ctl = addr_is(io_addr, `BOSR_ADDR_SLOT_CTL);
   wire logic hit_prs = addr_is(io_addr, `BOSR_ADDR_PRESENCE)
                        && sys_setup;
   wire logic hit_spd = addr_is(io_addr, `BOSR_ADDR_SPEED) && sys_setup
                        && (BOARD_VARIANT == bosr_pkg::BOSR_VAR_3);

   wire bosr_pkg::bosr_hit_t hit_kind =
      hit_ctl ? bosr_pkg::BOSR_HIT_CTL :
      hit_prs ? bosr_pkg::BOSR_HIT_PRS :
      hit_spd ? bosr_pkg::BOSR_HIT_SPD : bosr_pkg::BOSR_HIT_NONE;

   wire logic rd_take = io_strobe && !io_write
                        && (hit_kind != bosr_pkg::BOSR_HIT_NONE);
   wire logic wr_ctl  = io_strobe && io_write && hit_ctl;

   // Presence layouts of the first two variants share positions
   logic [7:0] prs_v12;
   always_comb begin
      prs_v12 = 8'h00;
      prs_v12[`BOSR_PRS_C2_TYPEA] = type_strap_a[1];
      prs_v12[`BOSR_PRS_C2_PRES]  = mem_present_n[1];
      prs_v12[`BOSR_PRS_C1_TYPEA] = type_strap_a[0];
      prs_v12[`BOSR_PRS_C1_PRES]  = mem_present_n[0];
   end

   // Presence layout of the third variant
   logic [7:0] prs_v3;
   always_comb begin
      prs_v3 = 8'h00;
      prs_v3[`BOSR_PRS_C2_TYPEB]   = type_strap_b[1];
      prs_v3[`BOSR_PRS_C2_TYPEA]   = type_strap_a[1];
      prs_v3[`BOSR_PRS_C1_TYPEB]   = type_strap_b[0];
      prs_v3[`BOSR_PRS_C1_TYPEA]   = type_strap_a[0];
      prs_v3[`BOSR_PRS_SERVICE]    = service_override_n;
      prs_v3[`BOSR_PRS_V3_C1_PRES] = mem_present_n[0];
      prs_v3[`BOSR_PRS_V3_C2_PRES] = mem_present_n[1];
   end

   // Speed and option register of the third variant
   logic [7:0] spd_v3;
   always_comb begin
      spd_v3 = 8'h00;
      spd_v3[`BOSR_SPD_C2_FAST] = slot2_fast_mem_n;
      spd_v3[`BOSR_SPD_C1_FAST] = slot1_fast_mem_n;
      spd_v3[`BOSR_SPD_CID_HI]  = cache_card_id[1];
      spd_v3[`BOSR_SPD_CID_LO]  = cache_card_id[0];
      spd_v3[`BOSR_SPD_WIN_OFF] = ram_window_strap;
   end

   // Control readback with the reserved bits forced high
   logic [7:0] ctl_read;
   always_comb begin
      ctl_read = `BOSR_CTL_RSVD_ONES;
      ctl_read[`BOSR_CTL_RESET_BIT]  = ctl_reset;
      ctl_read[`BOSR_CTL_ENABLE_BIT] = ctl_enable;
      ctl_read[`BOSR_CTL_SEL_HI:`BOSR_CTL_SEL_LO] = ctl_sel;
   end

   // Read data selection
   wire logic [7:0] prs_read =
      (BOARD_VARIANT == bosr_pkg::BOSR_VAR_3) ? prs_v3 : prs_v12;
   logic [7:0] next_rdata;
   always_comb begin
      case (hit_kind)
         bosr_pkg::BOSR_HIT_CTL: next_rdata = ctl_read;
         bosr_pkg::BOSR_HIT_PRS: next_rdata = prs_read;
         bosr_pkg::BOSR_HIT_SPD: next_rdata = spd_v3;
         default:                next_rdata = 8'h00;
      endcase
   end

   // Connector select: only inside an option cycle with enable set
   wire logic sel_win = io_active && addr_in_opt(io_addr)
                        && ctl_enable;
   logic [NSLOT-1:0] next_select_n;
   genvar gi;
   generate
      for (gi = 0; gi < NSLOT; gi++) begin : g_slot
         assign next_select_n[gi] =
            !(sel_win && (ctl_sel == SEL_W'(gi)));
      end
   endgenerate

   // Window disable applies only where the option register exists
   wire logic next_win_off = (BOARD_VARIANT == bosr_pkg::BOSR_VAR_3)
                             && ram_window_strap;

   // Control register writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_reset  <= 1'(`BOSR_CTL_RESET_VAL >> `BOSR_CTL_RESET_BIT);
         ctl_enable <= 1'b0;
         ctl_sel    <= '0;
      end else if (ce && wr_ctl) begin
         ctl_reset  <= io_wdata[`BOSR_CTL_RESET_BIT];
         ctl_enable <= io_wdata[`BOSR_CTL_ENABLE_BIT];
         ctl_sel    <= io_wdata[`BOSR_CTL_SEL_HI:`BOSR_CTL_SEL_LO];
      end
   end

   // Read answer, one cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         io_rdata  <= 8'h00;
         io_rvalid <= 1'b0;
      end else if (ce) begin
         io_rvalid <= rd_take;
         io_rdata  <= rd_take ? next_rdata : 8'h00;
      end
   end

   // Registered connector and board outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         chan_reset           <= 1'b0;
         slot_config_select_n <= '1;
         ram_window_off       <= 1'b0;
      end else if (ce) begin
         chan_reset           <= ctl_reset;
         slot_config_select_n <= next_select_n;
         ram_window_off       <= next_win_off;
      end
   end

   // Helper state for the checks below
   logic ce_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ce_q <= 1'b0;
      end else begin
         ce_q <= ce;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_RESET_FOLLOWS_WRITE:
   assert property (ce && wr_ctl && io_wdata[7] ##1 ce
                    |=> chan_reset)
      else $error("channel reset did not follow control write");

   AST_SELECT_ONLY_IN_WINDOW:
   assert property (ce_q && (slot_config_select_n != '1)
                    |-> $past(io_active && addr_in_opt(io_addr)))
      else $error("connector select outside option window");

   AST_SELECT_NEEDS_ENABLE:
   assert property (ce_q && !$past(ctl_enable)
                    |-> slot_config_select_n == '1)
      else $error("connector select without enable");

   AST_SELECT_ONE_HOT:
   assert property ($onehot0(~slot_config_select_n))
      else $error("more than one connector selected");

   AST_SELECT_INDEX:
   assert property (ce_q && (slot_config_select_n != '1)
                    |-> ~slot_config_select_n ==
                        (NSLOT'(1) << $past(ctl_sel)))
      else $error("wrong connector selected");

   AST_PRESENCE_NEEDS_SETUP:
   assert property (ce && io_strobe && !io_write && !sys_setup
                    && addr_is(io_addr, `BOSR_ADDR_PRESENCE)
                    |=> !io_rvalid)
      else $error("presence read answered outside setup");

   AST_READ_ANSWER:
   assert property (ce && io_strobe && !io_write && hit_ctl
                    |=> io_rvalid && (io_rdata[6:4] == 3'h7)
                        && (io_rdata[3] == ctl_enable))
      else $error("control readback wrong");

   AST_SERVICE_BIT:
   assert property (ce && rd_take && hit_prs
                    && (BOARD_VARIANT == bosr_pkg::BOSR_VAR_3)
                    |=> io_rdata[4] == $past(service_override_n))
      else $error("service override bit wrong");

   AST_WINDOW_OFF:
   assert property (ce_q |-> ram_window_off ==
                    ($past(ram_window_strap)
                     && (BOARD_VARIANT == bosr_pkg::BOSR_VAR_3)))
      else $error("window disable does not follow strap");

   AST_SPEED_REG_ONLY_V3:
   assert property (ce && io_strobe && !io_write
                    && addr_is(io_addr, `BOSR_ADDR_SPEED)
                    && (BOARD_VARIANT != bosr_pkg::BOSR_VAR_3)
                    |=> !io_rvalid)
      else $error("speed register answered on wrong variant");

   AST_RVALID_PULSE:
   assert property (io_rvalid && ce && !rd_take |=> !io_rvalid)
      else $error("read answer held too long");

   COV_SELECT_SLOT8:
   cover property (slot_config_select_n == 8'h7f);

   COV_CHAN_RESET:
   cover property (!chan_reset ##1 chan_reset);

   COV_PRESENCE_READ:
   cover property (ce && rd_take && hit_prs ##1 io_rvalid);

   COV_SPEED_READ:
   cover property (ce && rd_take && hit_spd ##1 io_rvalid);

endmodule // bosr_regs

// file: pkg/bosr_defs.svh
`ifndef BOSR_DEFS_SVH
`define BOSR_DEFS_SVH

// Register addresses in I/O space
`define BOSR_ADDR_SLOT_CTL   16'h0096
`define BOSR_ADDR_PRESENCE   16'h0103
`define BOSR_ADDR_SPEED      16'h0104
`define BOSR_ADDR_OPT_LO     16'h0100
`define BOSR_ADDR_OPT_HI     16'h0107

// Fields of slot_setup_control
`define BOSR_CTL_RESET_BIT   7
`define BOSR_CTL_ENABLE_BIT  3
`define BOSR_CTL_SEL_HI      2
`define BOSR_CTL_SEL_LO      0
`define BOSR_CTL_RSVD_ONES   8'h70
`define BOSR_CTL_RESET_VAL   8'h00

// Fields of the presence register
`define BOSR_PRS_C2_TYPEB    6
`define BOSR_PRS_C1_TYPEB    5
`define BOSR_PRS_SERVICE     4
`define BOSR_PRS_C2_TYPEA    3
`define BOSR_PRS_C2_PRES     2
`define BOSR_PRS_C1_TYPEA    1
`define BOSR_PRS_C1_PRES     0
`define BOSR_PRS_V3_C1_PRES  2
`define BOSR_PRS_V3_C2_PRES  0

// Fields of the speed and option register
`define BOSR_SPD_C2_FAST     5
`define BOSR_SPD_C1_FAST     4
`define BOSR_SPD_CID_HI      3
`define BOSR_SPD_CID_LO      2
`define BOSR_SPD_WIN_OFF     0

`endif

// file: pkg/bosr_pkg.sv
package bosr_pkg;

   // Board variants that choose the presence register layout
   typedef enum logic [1:0] {
      BOSR_VAR_1 = 2'h1,
      BOSR_VAR_2 = 2'h2,
      BOSR_VAR_3 = 2'h3
   } bosr_variant_t;

   // Kind of register an I/O address decodes to
   typedef enum logic [1:0] {
      BOSR_HIT_NONE  = 2'h0,
      BOSR_HIT_CTL   = 2'h1,
      BOSR_HIT_PRS   = 2'h3,
      BOSR_HIT_SPD   = 2'h2
   } bosr_hit_t;

endpackage

// file: verification/bosr_card_model.sv
`timescale 1ns/1ps
// Expansion cards: each one enters setup when its select line is low
module bosr_card_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Connector lines from the board
   input  wire logic       chan_reset,
   input  wire logic [7:0] slot_config_select_n,
   // Observed card state
   output logic [3:0]      sel_slot,
   output logic            card_reset
);
   // Connector number of the card in setup, 0 when none answers option cycles
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel_slot <= 4'h0;
         card_reset <= 1'b0;
      end else begin
         card_reset <= chan_reset;
         sel_slot <= 4'h0;
         for (int i = 0; i < 8; i++) begin
            if (!slot_config_select_n[i]) begin
               sel_slot <= 4'(i + 1);
            end
         end
      end
   end
endmodule // bosr_card_model

// file: verification/bosr_regs_tb.sv
`timescale 1ns/1ps
module bosr_regs_tb;
   logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, io_active = 1'b0, io_strobe = 1'b0;
   logic io_write = 1'b0, svc = 1'b1, s1f = 1'b0, s2f = 1'b1, win = 1'b0, sys_setup = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00, io_rdata, rd1, sel_n, rd, rdv1;
   logic [1:0]  tsa = 2'h0, tsb = 2'h0, mp = 2'h0, cid = 2'h0;
   logic        rvalid, rv, rv1, rvv1, chan_reset, win_off;
   logic [3:0]  sel_slot;
   logic        card_reset;
   int          fail_count = 0, compares = 0;

   // Clock of 5 ns period
   always #2.5 mclk = ~mclk;

   bosr_regs uut (.mclk(mclk), .rst(rst), .ce(ce), .io_active(io_active),
      .io_strobe(io_strobe), .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .io_rvalid(rvalid), .sys_setup(sys_setup), .type_strap_a(tsa),
      .type_strap_b(tsb), .mem_present_n(mp), .service_override_n(svc),
      .slot1_fast_mem_n(s1f), .slot2_fast_mem_n(s2f), .cache_card_id(cid),
      .ram_window_strap(win), .ram_window_off(win_off), .chan_reset(chan_reset),
      .slot_config_select_n(sel_n));
   // Variant 1 board sharing the same inputs
   bosr_regs #(.BOARD_VARIANT(bosr_pkg::BOSR_VAR_1)) uut_v1 (.mclk(mclk), .rst(rst),
      .ce(ce), .io_active(io_active), .io_strobe(io_strobe), .io_write(io_write),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(rd1), .io_rvalid(rv1),
      .sys_setup(sys_setup), .type_strap_a(tsa), .type_strap_b(tsb), .mem_present_n(mp),
      .service_override_n(svc), .slot1_fast_mem_n(s1f), .slot2_fast_mem_n(s2f),
      .cache_card_id(cid), .ram_window_strap(win), .ram_window_off(), .chan_reset(),
      .slot_config_select_n());
   bosr_card_model cards (.mclk(mclk), .rst(rst), .chan_reset(chan_reset),
      .slot_config_select_n(sel_n), .sel_slot(sel_slot), .card_reset(card_reset));

   // Compare one value and count it
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One strobed I/O cycle; answer sampled one edge later, then one idle edge
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
      io_strobe = 1'b1;
      io_write = w;
      io_addr = a;
      io_wdata = d;
      @(posedge mclk);
      #1;
      rd = io_rdata;
      rv = rvalid;
      rdv1 = rd1;
      rvv1 = rv1;
      io_strobe = 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #20000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(posedge mclk);
      #1;
      rst = 1'b0;
      tick();
      check("sel_idle", sel_n, 8'hff);
      io(1'b0, 16'h0096, 8'h00);
      check("ctl_rst", {7'h0, rv}, 8'h01);
      check("ctl_rst_d", rd, 8'h70);
      // Channel reset follows bit 7, reserved bits read as ones
      io(1'b1, 16'h0096, 8'h8a);
      tick();
      check("chan_reset", {7'h0, chan_reset}, 8'h01);
      io(1'b0, 16'h0096, 8'h00);
      check("ctl_rd", rd, 8'hfa);
      check("card_reset", {7'h0, card_reset}, 8'h01);
      io(1'b1, 16'h0103, 8'h55);
      io(1'b0, 16'h0096, 8'h00);
      check("ctl_keep", rd, 8'hfa);
      io(1'b1, 16'h0096, 8'h02);
      tick();
      check("chan_off", {7'h0, chan_reset}, 8'h00);
      // Each connector, selected only inside the option window
      for (int i = 0; i < 8; i++) begin
         io(1'b1, 16'h0096, 8'h08 | 8'(i));
         tick();
         check("sel_noio", sel_n, 8'hff);
         io_active = 1'b1;
         io_addr = 16'h0100 + 16'(7 - i);
         tick();
         check("sel_on", sel_n, ~(8'h01 << i));
         tick();
         check("card", {4'h0, sel_slot}, 8'(i + 1));
         io_addr = 16'h0108;
         tick();
         check("sel_out", sel_n, 8'hff);
         io_active = 1'b0;
      end
      io(1'b1, 16'h0096, 8'h05);
      io_active = 1'b1;
      io_addr = 16'h0100;
      tick();
      tick();
      check("sel_dis", sel_n, 8'hff);
      io_active = 1'b0;
      // Board registers refused outside setup mode
      io(1'b0, 16'h0103, 8'h00);
      check("prs_nosetup", {7'h0, rv}, 8'h00);
      io(1'b0, 16'h0104, 8'h00);
      check("spd_nosetup", {7'h0, rv}, 8'h00);
      sys_setup = 1'b1;
      for (int k = 0; k < 4; k++) begin
         tsa = 2'(k);
         tsb = ~2'(k);
         mp = 2'(k) ^ 2'h1;
         svc = k[0];
         s1f = k[1];
         s2f = ~k[0];
         cid = 2'(3 - k);
         win = k[0];
         tick();
         io(1'b0, 16'h0103, 8'h00);
         check("prs3_v", {7'h0, rv}, 8'h01);
         check("prs3", rd, {1'b0, tsb[1], tsb[0], svc, 1'b0, 3'h0} |
            {4'h0, tsa[1], mp[0], tsa[0], mp[1]});
         check("prs1", rdv1, {4'h0, tsa[1], mp[1], tsa[0], mp[0]});
         io(1'b0, 16'h0104, 8'h00);
         check("spd", rd, {2'h0, s2f, s1f, cid, 1'b0, win});
         check("spd_v1", {7'h0, rvv1}, 8'h00);
         check("win_off", {7'h0, win_off}, {7'h0, win});
      end
      io(1'b0, 16'h0097, 8'h00);
      check("unmapped", {7'h0, rv}, 8'h00);
      // Option window belongs to the adapter; the board gives no answer at 0100
      io(1'b0, 16'h0100, 8'h00);
      check("opt_none", {7'h0, rv}, 8'h00);
      tally_and_finish();
   end
endmodule // bosr_regs_tb
